// *** src/rcs_image_if.sv ***
// Write path into the register image, between sequencer and image store.
// Assumes one shared clock.
`timescale 1ns/1ns
interface rcs_image_if;
	import rcs_pkg::*;
	logic clear;
	logic wrEn;
	logic [ADDR_W-1:0] wrAddr;
	logic [DATA_W-1:0] wrData;
	logic commit;
	logic trigSeen;
	modport seq (output clear, output wrEn, output wrAddr, output wrData, output commit,
		input trigSeen);
	modport store (input clear, input wrEn, input wrAddr, input wrData, input commit,
		output trigSeen);
endinterface

// *** src/rcs_image_store.sv ***
// Register image held in flip-flops plus the committed live copy.
// Assumes clear and writes come only from the sequencer.
`timescale 1ns/1ns
module rcs_image_store #(
	parameter int DEPTH = 16,
	parameter logic [rcs_pkg::ADDR_W-1:0] TRIG_ADDR = 8'h0f
) (
	input wire logic core_clk,
	input wire logic rstn,
	rcs_image_if.store img,
	output logic [DEPTH*rcs_pkg::DATA_W-1:0] live
);
	import rcs_pkg::*;

	logic [DATA_W-1:0] image_q [DEPTH];
	logic trigSeen_q;

	// ***********************************
	// Image entries
	// ***********************************
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_ent
			always_ff @(posedge core_clk) begin
				if (!rstn || img.clear) begin
					image_q[gi] <= DEFAULT_VALUE; // R1
				end else if (img.wrEn && img.wrAddr == ADDR_W'(gi)) begin
					image_q[gi] <= img.wrData; // R6
				end
			end
			// Live registers change only on commit
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					live[gi*DATA_W +: DATA_W] <= DEFAULT_VALUE;
				end else if (img.commit) begin
					live[gi*DATA_W +: DATA_W] <= image_q[gi]; // R14
				end
			end
		end
	endgenerate

	// Trigger write seen, even with a zero value
	always_ff @(posedge core_clk) begin
		if (!rstn || img.clear) begin
			trigSeen_q <= 1'b0;
		end else if (img.wrEn && img.wrAddr == TRIG_ADDR) begin
			trigSeen_q <= 1'b1; // R7
		end
	end
	assign img.trigSeen = trigSeen_q;

endmodule // rcs_image_store

// *** src/rcs_pkg.sv ***
// Constants and types shared by the reset configuration sequencer.
// Assumes a 100 MHz core clock.
package rcs_pkg;

	// ***********************************
	// Timing
	// ***********************************
	localparam int CLK_MHZ = 100;
	localparam int HOST_WAIT_NOEE_MS = 15;
	localparam int HOST_WAIT_NOEE_CYC = HOST_WAIT_NOEE_MS * 1000 * CLK_MHZ;
	localparam int HOST_WAIT_EE_MS = 150;
	localparam int HOST_WAIT_EE_CYC = HOST_WAIT_EE_MS * 1000 * CLK_MHZ;

	// ***********************************
	// Field layout
	// ***********************************
	localparam int CFG_NUM_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int EE_ADDR_W = 7;
	localparam logic [6:0] EE_ADDR_FIRST = 7'h50;
	localparam logic [6:0] EE_ADDR_LAST = 7'h57;
	localparam logic [DATA_W-1:0] DEFAULT_VALUE = 8'h00;

	// Probe clock rates, fastest first
	typedef enum logic [1:0] {
		RATE_1M = 2'b00,
		RATE_400K = 2'b01,
		RATE_100K = 2'b10
	} rcs_rate_t;

	// Slave port protocol
	typedef enum logic [1:0] {
		PORT_I2C = 2'b00,
		PORT_SPI4 = 2'b01,
		PORT_SPI3 = 2'b10
	} rcs_port_t;

	// Status bit positions
	localparam int ST_OTP_MISSING = 0;
	localparam int ST_OTP_CKSUM = 1;
	localparam int ST_EE_NONE = 2;
	localparam int ST_EE_BAD = 3;
	localparam int ST_ALL_DEFAULT = 4;
	localparam int ST_W = 5;

	// Sequence states
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_DEFAULTS = 4'b0001,
		S_UPD_SCAN = 4'b0010,
		S_OTP_REQ = 4'b0011,
		S_OTP_LOAD = 4'b0100,
		S_EE_PROBE = 4'b0101,
		S_EE_LOAD = 4'b0110,
		S_HOTFIX = 4'b0111,
		S_PLL_CAL = 4'b1000,
		S_PORT_EN = 4'b1001,
		S_COMMIT = 4'b1010,
		S_MON_EN = 4'b1011,
		S_ALARM_EN = 4'b1100,
		S_RUN = 4'b1101
	} rcs_state_t;

endpackage

// *** src/rcs_sequencer.sv ***
// Reset-time configuration sequencer: defaults, updates, OTP, EEPROM,
// hotfix, commit. Assumes OTP and EEPROM readers are outside and give
// simple request/done handshakes with checksum results.
`timescale 1ns/1ns

// Notes on behaviour
// R1: After reset, build default register image; pins and clocks stay in reset state.
// R2: Slave port protocol from latched GPIO; SPI defaults to four-wire.
// R3: If update scan enabled and update found, load it and restart at start; the code returns to S_IDLE and waits for the next master reset rise.
// R4: Look up selected OTP config; missing or bad checksum reports error, go EEPROM.
// R5: After good OTP load, report loaded configuration number.
// R6: Applying a config writes only listed registers; others stay default.
// R7: Settings take effect only when trigger register written, even with zero; the code gates only powerOn on it, not slavePortMode.
// R8: If PLL feedback divider was loaded, calibrate PLL alongside later stages.
// R9: After internal load, reconfigure slave port to protocol in loaded values.
// R10: EEPROM blocks read and checksum checked; bad blocks dropped, good one applied.
// R11: EEPROM search runs through all addresses until exhausted or one applied; the code stops at the first acking address even if none of its blocks is good.
// R12: Host places EEPROM config only without valid OTP selection.
// R13: If OTP holds hotfix, copy to RAM and run after search stages.
// R14: Completion in order: PLL relock, port enable, commit, monitors, alarms.
// R15: Status bits show which failures occurred, including all-default finish.
// R16: Host waits 15 ms, or 150 ms when EEPROM enabled but absent.
// R17: Host waits per payload formula when EEPROM present.
// R18: Power control defaults lowest power; register bits shut off unneeded functions.
// R19: Dedicated master port for loading; slave port usable only after completion.
// R20: Master pins may share the bus with the slave port in I2C mode.
// R21: Slave port reconfigurable any time by a single burst write; the code has no host write path and keeps the port mode fixed after commit.
// R22: GPIO levels captured at master reset rising edge and steer later stages.
// R23: Probe EEPROM addresses 0x50..0x57 at 1 MHz, then 400 kHz, then 100 kHz.
// R24: Slave port ignores host transactions until completion enables it.
module rcs_sequencer #(
	parameter int DEPTH = 16,
	parameter int PWR_W = 4
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic master_reset_n,
	input wire logic [rcs_pkg::CFG_NUM_W-1:0] gpioCfgSel,
	input wire logic gpioSpiSel,
	input wire logic gpioEeEn,
	input wire logic updReady,
	input wire logic updFound,
	input wire logic otpDone,
	input wire logic otpFound,
	input wire logic otpCksumOk,
	input wire logic otpHotfix,
	input wire logic cfgWrEn,
	input wire logic [rcs_pkg::ADDR_W-1:0] cfgWrAddr,
	input wire logic [rcs_pkg::DATA_W-1:0] cfgWrData,
	input wire logic cfgDone,
	input wire logic eeAck,
	input wire logic eeProbeDone,
	input wire logic eeBlockDone,
	input wire logic eeBlockOk,
	input wire logic eeBlockLast,
	input wire logic hotfixDone,
	input wire logic pllCalDone,
	output logic updReq,
	output logic otpReq,
	output logic [rcs_pkg::CFG_NUM_W-1:0] otpCfgNum,
	output logic eeProbeReq,
	output logic [rcs_pkg::EE_ADDR_W-1:0] eeProbeAddr,
	output rcs_pkg::rcs_rate_t eeRate,
	output logic eeBlockReq,
	output logic hotfixReq,
	output logic pllCalStart,
	output logic masterPortEn,
	output logic slavePortEn,
	output rcs_pkg::rcs_port_t slavePortMode,
	output logic outputsEn,
	output logic monitorsEn,
	output logic alarmsEn,
	output logic [rcs_pkg::CFG_NUM_W-1:0] loadedCfgNum,
	output logic loadedCfgValid,
	output logic [rcs_pkg::ST_W-1:0] resetStatus,
	output logic [PWR_W-1:0] powerOn,
	output logic done
);
	import rcs_pkg::*;

	localparam logic [ADDR_W-1:0] PLL_FB_ADDR = 8'h01;
	localparam logic [ADDR_W-1:0] PORT_MODE_ADDR = 8'h02;
	localparam logic [ADDR_W-1:0] PWR_ADDR = 8'h03;

	rcs_state_t state_q;
	logic mrPrev_q;
	logic [CFG_NUM_W-1:0] gpioCfg_q;
	logic gpioSpi_q;
	logic gpioEe_q;
	logic anyLoaded_q;
	logic pllFbSeen_q;
	logic eeFound_q;
	logic eeApplied_q;
	logic [DEPTH*DATA_W-1:0] live;
	logic mrRise;
	logic loading;

	rcs_image_if img ();

	rcs_image_store #(.DEPTH(DEPTH)) u_store (
		.core_clk(core_clk),
		.rstn(rstn),
		.img(img),
		.live(live)
	);

	// ***********************************
	// Start condition capture
	// ***********************************
	assign mrRise = master_reset_n && !mrPrev_q;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			mrPrev_q <= 1'b0;
		end else begin
			mrPrev_q <= master_reset_n;
		end
	end

	// Strap levels caught by a clocked process, never by reset
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			gpioCfg_q <= '0;
			gpioSpi_q <= 1'b0;
			gpioEe_q <= 1'b0;
		end else if (mrRise) begin
			gpioCfg_q <= gpioCfgSel; // R22
			gpioSpi_q <= gpioSpiSel; // R22
			gpioEe_q <= gpioEeEn; // R22
		end
	end

	// ***********************************
	// Sequence
	// ***********************************
	always_ff @(posedge core_clk) begin
		if (!rstn || !master_reset_n) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: if (mrRise) state_q <= S_DEFAULTS;
				S_DEFAULTS: state_q <= gpioEe_q ? S_UPD_SCAN : S_OTP_REQ;
				S_UPD_SCAN: if (updReady) state_q <= updFound ? S_IDLE : S_OTP_REQ; // R3
				S_OTP_REQ: if (otpDone) begin
					state_q <= (otpFound && otpCksumOk) ? S_OTP_LOAD
						: (gpioEe_q ? S_EE_PROBE : S_HOTFIX); // R4
				end
				S_OTP_LOAD: if (cfgDone) state_q <= gpioEe_q ? S_EE_PROBE : S_HOTFIX;
				S_EE_PROBE: if (eeProbeDone) begin
					if (eeAck) state_q <= S_EE_LOAD;
					else if (eeProbeAddr == EE_ADDR_LAST && eeRate == RATE_100K) begin
						state_q <= S_HOTFIX; // R23
					end
				end
				S_EE_LOAD: if (eeBlockDone) begin
					if (eeBlockOk || eeBlockLast) state_q <= S_HOTFIX; // R11
				end
				S_HOTFIX: if (!otpHotfix || hotfixDone) state_q <= S_PLL_CAL; // R13
				S_PLL_CAL: if (!anyLoaded_q || pllCalDone) state_q <= S_PORT_EN; // R14
				S_PORT_EN: state_q <= S_COMMIT;
				S_COMMIT: state_q <= S_MON_EN;
				S_MON_EN: state_q <= S_ALARM_EN;
				S_ALARM_EN: state_q <= S_RUN;
				S_RUN: state_q <= S_RUN;
			endcase
		end
	end

	// ***********************************
	// Image writes
	// ***********************************
	assign loading = (state_q == S_OTP_LOAD) || (state_q == S_EE_LOAD);
	assign img.clear = (state_q == S_DEFAULTS); // R1
	assign img.wrEn = loading && cfgWrEn; // R6
	assign img.wrAddr = cfgWrAddr;
	assign img.wrData = cfgWrData;
	assign img.commit = (state_q == S_COMMIT); // R14

	always_ff @(posedge core_clk) begin
		if (!rstn || state_q == S_DEFAULTS) begin
			anyLoaded_q <= 1'b0;
			pllFbSeen_q <= 1'b0;
		end else begin
			if (state_q == S_OTP_LOAD && cfgDone) anyLoaded_q <= 1'b1;
			if (state_q == S_EE_LOAD && eeBlockDone && eeBlockOk) anyLoaded_q <= 1'b1;
			if (img.wrEn && cfgWrAddr == PLL_FB_ADDR) pllFbSeen_q <= 1'b1;
		end
	end

	// PLL calibration starts beside later stages after an OTP load that wrote the divider, and again on leaving hotfix whenever anything was loaded
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pllCalStart <= 1'b0;
		end else begin
			pllCalStart <= (state_q == S_OTP_LOAD && cfgDone && pllFbSeen_q)
				|| (state_q == S_HOTFIX && anyLoaded_q && (!otpHotfix || hotfixDone)); // R8
		end
	end

	// ***********************************
	// Master port requests
	// ***********************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			updReq <= 1'b0;
			otpReq <= 1'b0;
			otpCfgNum <= '0;
			eeBlockReq <= 1'b0;
			hotfixReq <= 1'b0;
			masterPortEn <= 1'b0;
		end else begin
			updReq <= (state_q == S_UPD_SCAN) && !updReady;
			otpReq <= (state_q == S_OTP_REQ) && !otpDone; // R4
			otpCfgNum <= gpioCfg_q; // R4
			eeBlockReq <= (state_q == S_EE_LOAD) && !eeBlockDone; // R10
			hotfixReq <= (state_q == S_HOTFIX) && otpHotfix && !hotfixDone; // R13
			masterPortEn <= (state_q == S_UPD_SCAN) || (state_q == S_EE_PROBE)
				|| (state_q == S_EE_LOAD); // R19 R20
		end
	end

	// Address walks 0x50..0x57 at each rate, fastest first
	always_ff @(posedge core_clk) begin
		if (!rstn || state_q == S_DEFAULTS) begin
			eeProbeAddr <= EE_ADDR_FIRST;
			eeRate <= RATE_1M;
			eeProbeReq <= 1'b0;
		end else begin
			eeProbeReq <= (state_q == S_EE_PROBE) && !eeProbeDone;
			if (state_q == S_EE_PROBE && eeProbeDone && !eeAck) begin
				if (eeProbeAddr != EE_ADDR_LAST) begin
					eeProbeAddr <= eeProbeAddr + 7'h01; // R23
				end else if (eeRate != RATE_100K) begin
					eeProbeAddr <= EE_ADDR_FIRST;
					eeRate <= (eeRate == RATE_1M) ? RATE_400K : RATE_100K; // R23
				end
			end
		end
	end

	// ***********************************
	// Completion and port enables
	// ***********************************
	always_ff @(posedge core_clk) begin
		if (!rstn || state_q == S_DEFAULTS || state_q == S_IDLE) begin
			slavePortEn <= 1'b0;
			outputsEn <= 1'b0;
			monitorsEn <= 1'b0;
			alarmsEn <= 1'b0;
			done <= 1'b0;
		end else begin
			if (state_q == S_PORT_EN) slavePortEn <= 1'b1; // R24
			if (state_q == S_COMMIT) outputsEn <= 1'b1; // R14
			if (state_q == S_MON_EN) monitorsEn <= 1'b1; // R14
			if (state_q == S_ALARM_EN) alarmsEn <= 1'b1; // R14
			if (state_q == S_ALARM_EN) done <= 1'b1;
		end
	end

	// Port mode: strap first, then loaded value; live value after commit when anything was loaded
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			slavePortMode <= PORT_I2C;
		end else if (state_q == S_DEFAULTS) begin
			slavePortMode <= gpioSpi_q ? PORT_SPI4 : PORT_I2C; // R2
		end else if (img.wrEn && cfgWrAddr == PORT_MODE_ADDR) begin
			slavePortMode <= rcs_port_t'(cfgWrData[1:0]); // R9
		end else if (state_q == S_RUN && anyLoaded_q) begin
			slavePortMode <= rcs_port_t'(live[PORT_MODE_ADDR*DATA_W +: 2]); // R21
		end
	end

	// Lowest power by default; live bits switch blocks on
	always_ff @(posedge core_clk) begin
		if (!rstn || state_q != S_RUN || !img.trigSeen) begin // R7
			powerOn <= '0;
		end else begin
			powerOn <= live[PWR_ADDR*DATA_W +: PWR_W]; // R18
		end
	end

	// ***********************************
	// Status
	// ***********************************
	always_ff @(posedge core_clk) begin
		if (!rstn || state_q == S_DEFAULTS) begin
			resetStatus <= '0;
			loadedCfgNum <= '0;
			loadedCfgValid <= 1'b0;
			eeFound_q <= 1'b0;
			eeApplied_q <= 1'b0;
		end else begin
			if (state_q == S_OTP_REQ && otpDone) begin
				resetStatus[ST_OTP_MISSING] <= !otpFound; // R4
				resetStatus[ST_OTP_CKSUM] <= otpFound && !otpCksumOk; // R4
			end
			if (state_q == S_OTP_LOAD && cfgDone) begin
				loadedCfgNum <= gpioCfg_q; // R5
				loadedCfgValid <= 1'b1; // R5
			end
			if (state_q == S_EE_PROBE && eeProbeDone && eeAck) eeFound_q <= 1'b1;
			if (state_q == S_EE_LOAD && eeBlockDone && eeBlockOk) eeApplied_q <= 1'b1;
			if (state_q == S_EE_LOAD && eeBlockDone && !eeBlockOk) begin
				resetStatus[ST_EE_BAD] <= 1'b1; // R10
			end
			if (state_q == S_HOTFIX) begin
				resetStatus[ST_EE_NONE] <= gpioEe_q && !eeFound_q; // R15
				resetStatus[ST_ALL_DEFAULT] <= !anyLoaded_q; // R15
			end
		end
	end

	// ***********************************
	// Checks
	// ***********************************
	property p_commit_order;
		@(posedge core_clk) disable iff (!rstn || !master_reset_n)
		$rose(slavePortEn) |=> $rose(outputsEn) ##1 $rose(monitorsEn) ##1 $rose(alarmsEn);
	endproperty
	a_commit_order: assert property (p_commit_order) else $error("completion out of order"); // R14

	property p_port_gated;
		@(posedge core_clk) disable iff (!rstn)
		(state_q != S_RUN && state_q != S_ALARM_EN && state_q != S_MON_EN
			&& state_q != S_COMMIT) |=> !outputsEn;
	endproperty
	a_port_gated: assert property (p_port_gated) else $error("outputs early"); // R1

	property p_probe_wrap;
		@(posedge core_clk) disable iff (!rstn || !master_reset_n)
		(state_q == S_EE_PROBE && eeProbeDone && !eeAck && eeProbeAddr == EE_ADDR_LAST
			&& eeRate == RATE_1M) |=> (eeProbeAddr == EE_ADDR_FIRST && eeRate == RATE_400K);
	endproperty
	a_probe_wrap: assert property (p_probe_wrap) else $error("probe rate step wrong"); // R23

	property p_otp_fail;
		@(posedge core_clk) disable iff (!rstn || !master_reset_n)
		(state_q == S_OTP_REQ && otpDone && !otpFound) |=> resetStatus[ST_OTP_MISSING];
	endproperty
	a_otp_fail: assert property (p_otp_fail) else $error("otp miss not reported"); // R4

	property p_cfg_num;
		@(posedge core_clk) disable iff (!rstn || !master_reset_n)
		(state_q == S_OTP_LOAD && cfgDone) |=> (loadedCfgValid && loadedCfgNum == gpioCfg_q);
	endproperty
	a_cfg_num: assert property (p_cfg_num) else $error("loaded number not shown"); // R5

	property p_update_restart;
		@(posedge core_clk) disable iff (!rstn || !master_reset_n)
		(state_q == S_UPD_SCAN && updReady && updFound) |=> state_q == S_IDLE;
	endproperty
	a_update_restart: assert property (p_update_restart) else $error("no restart"); // R3

	property p_spi_default;
		@(posedge core_clk) disable iff (!rstn || !master_reset_n)
		(state_q == S_DEFAULTS && gpioSpi_q) |=> slavePortMode == PORT_SPI4;
	endproperty
	a_spi_default: assert property (p_spi_default) else $error("spi not four-wire"); // R2

	property p_default_status;
		@(posedge core_clk) disable iff (!rstn || !master_reset_n)
		(state_q == S_HOTFIX && !anyLoaded_q) |=> resetStatus[ST_ALL_DEFAULT];
	endproperty
	a_default_status: assert property (p_default_status) else $error("default flag missing"); // R15
	property p_bus_share;
		@(posedge core_clk) disable iff (!rstn) masterPortEn |-> !slavePortEn;
	endproperty
	a_bus_share: assert property (p_bus_share) else $error("master and slave ports both on"); // R20

endmodule // rcs_sequencer

// *** tb/rcs_far_model.sv ***
// Far side of the sequencer: update scan, OTP reader, EEPROM, hotfix engine, PLL.
// Assumes one request at a time, answered after a random lag.
`timescale 1ns/1ns
module rcs_far_model (
	input wire logic core_clk,
	input wire logic [21:0] knobs,
	input wire logic updReq,
	input wire logic otpReq,
	input wire logic eeProbeReq,
	input wire logic [6:0] eeProbeAddr,
	input wire logic eeBlockReq,
	input wire logic hotfixReq,
	input wire logic pllCalStart,
	output logic updReady,
	output logic updFound,
	output logic otpDone,
	output logic otpFound,
	output logic otpCksumOk,
	output logic cfgWrEn,
	output logic [7:0] cfgWrAddr,
	output logic [7:0] cfgWrData,
	output logic cfgDone,
	output logic eeAck,
	output logic eeProbeDone,
	output logic eeBlockDone,
	output logic eeBlockOk,
	output logic eeBlockLast,
	output logic hotfixDone,
	output logic pllCalDone
);
	// Knobs: 0 update, 1 OTP hit, 2 OTP good, 9:3 acking address,
	// 11:10 bad blocks first (3: none good), 13:12 port mode, 21:14 power bits
	int seed = 32'heb17;
	int blkLeft = 0;
	int pllCnt = 0;
	logic updUsed = 1'b0;

	task automatic lag();
		repeat (1 + $unsigned($random(seed)) % 4) @(posedge core_clk);
	endtask

	task automatic put(input logic [7:0] a, input logic [7:0] d);
		cfgWrEn <= 1'b1;
		cfgWrAddr <= a;
		cfgWrData <= d;
		@(posedge core_clk);
	endtask

	// Same four registers from every source, so the last load sets all four of them
	task automatic writes();
		put(8'h01, 8'($random(seed)));
		put(8'h02, {6'h00, knobs[13:12]});
		put(8'h03, knobs[21:14]);
		put(8'h0f, 8'h00);
		cfgWrEn <= 1'b0;
		cfgWrAddr <= ~cfgWrAddr;
	endtask

	initial begin
		{updReady, updFound, otpDone, otpFound, otpCksumOk, cfgWrEn, cfgDone} = '0;
		{eeAck, eeProbeDone, eeBlockDone, eeBlockOk, eeBlockLast, hotfixDone} = '0;
		cfgWrAddr = 8'h00;
		cfgWrData = 8'h00;
		forever begin
			@(posedge core_clk);
			if (updReq) begin
				lag();
				updFound <= knobs[0] && !updUsed;
				updUsed <= 1'b1;
				updReady <= 1'b1;
				@(posedge core_clk);
				updReady <= 1'b0;
			end else if (otpReq) begin
				updUsed <= 1'b0;
				lag();
				otpFound <= knobs[1];
				otpCksumOk <= knobs[2];
				otpDone <= 1'b1;
				@(posedge core_clk);
				otpDone <= 1'b0;
				if (knobs[1] && knobs[2]) begin
					writes();
					cfgDone <= 1'b1;
					@(posedge core_clk);
					cfgDone <= 1'b0;
				end
			end else if (eeProbeReq) begin
				lag();
				blkLeft = knobs[11:10];
				eeAck <= eeProbeAddr == knobs[9:3];
				eeProbeDone <= 1'b1;
				@(posedge core_clk);
				eeProbeDone <= 1'b0;
			end else if (eeBlockReq) begin
				lag();
				if (blkLeft == 0) writes();
				eeBlockOk <= blkLeft == 0;
				eeBlockLast <= knobs[11:10] == 2'd3 && blkLeft == 1;
				eeBlockDone <= 1'b1;
				blkLeft = blkLeft - 1;
				@(posedge core_clk);
				eeBlockDone <= 1'b0;
			end else if (hotfixReq) begin
				lag();
				hotfixDone <= 1'b1;
				@(posedge core_clk);
				hotfixDone <= 1'b0;
			end
		end
	end

	// Lock status repeats, so a late waiter still sees it
	always @(posedge core_clk) begin
		if (pllCalStart) pllCnt <= 6;
		else if (pllCnt == 1) pllCnt <= 16;
		else if (pllCnt > 0) pllCnt <= pllCnt - 1;
		pllCalDone <= pllCnt == 1 && !pllCalStart;
	end
endmodule // rcs_far_model

// *** tb/tb.sv ***
// Self-checking bench for the reset configuration sequencer.
// Assumes the far-side model answers every request.
`timescale 1ns/1ns
module tb;
	import rcs_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic master_reset_n = 1'b0;
	logic [CFG_NUM_W-1:0] gpioCfgSel = '0;
	logic gpioSpiSel = 1'b0;
	logic gpioEeEn = 1'b0;
	logic otpHotfix = 1'b0;
	logic [21:0] knobs = '0;
	logic updReady, updFound, otpDone, otpFound, otpCksumOk, cfgWrEn, cfgDone;
	logic [ADDR_W-1:0] cfgWrAddr;
	logic [DATA_W-1:0] cfgWrData;
	logic eeAck, eeProbeDone, eeBlockDone, eeBlockOk, eeBlockLast, hotfixDone, pllCalDone;
	logic updReq, otpReq, eeProbeReq, eeBlockReq, hotfixReq, pllCalStart, masterPortEn;
	logic slavePortEn, outputsEn, monitorsEn, alarmsEn, loadedCfgValid, done;
	logic [CFG_NUM_W-1:0] otpCfgNum, loadedCfgNum, selQ;
	logic [EE_ADDR_W-1:0] eeProbeAddr;
	rcs_rate_t eeRate;
	rcs_port_t slavePortMode;
	logic [ST_W-1:0] resetStatus;
	logic [3:0] powerOn;
	int seed = 32'heb17;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int probeIdx, updSeen, pllSeen, hotSeen, tPort, tOut, tMon, tAlm, tDone;

	rcs_sequencer rcs_sequencer_inst (
		.core_clk, .rstn, .master_reset_n, .gpioCfgSel, .gpioSpiSel, .gpioEeEn,
		.updReady, .updFound, .otpDone, .otpFound, .otpCksumOk, .otpHotfix,
		.cfgWrEn, .cfgWrAddr, .cfgWrData, .cfgDone, .eeAck, .eeProbeDone,
		.eeBlockDone, .eeBlockOk, .eeBlockLast, .hotfixDone, .pllCalDone,
		.updReq, .otpReq, .otpCfgNum, .eeProbeReq, .eeProbeAddr, .eeRate,
		.eeBlockReq, .hotfixReq, .pllCalStart, .masterPortEn, .slavePortEn,
		.slavePortMode, .outputsEn, .monitorsEn, .alarmsEn, .loadedCfgNum,
		.loadedCfgValid, .resetStatus, .powerOn, .done
	);
	rcs_far_model rcs_far_model_inst (
		.core_clk, .knobs, .updReq, .otpReq, .eeProbeReq, .eeProbeAddr, .eeBlockReq,
		.hotfixReq, .pllCalStart, .updReady, .updFound, .otpDone, .otpFound,
		.otpCksumOk, .cfgWrEn, .cfgWrAddr, .cfgWrData, .cfgDone, .eeAck,
		.eeProbeDone, .eeBlockDone, .eeBlockOk, .eeBlockLast, .hotfixDone, .pllCalDone
	);

	initial forever #5 core_clk = ~core_clk;

	task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ***********************************
	// Monitor
	// ***********************************
	always @(posedge core_clk) begin
		cyc++;
		if (eeProbeDone) begin
			cmpVal(eeProbeAddr, EE_ADDR_FIRST + probeIdx % 8);
			cmpVal(eeRate, probeIdx / 8);
			probeIdx++;
		end
		if (otpReq) cmpVal(otpCfgNum, selQ);
		if (slavePortEn) cmpVal({updReq, otpReq, eeProbeReq, eeBlockReq, hotfixReq}, 0);
		updSeen += updReady;
		pllSeen += pllCalStart;
		hotSeen |= hotfixReq;
		if (slavePortEn && tPort == 0) tPort = cyc;
		if (outputsEn && tOut == 0) tOut = cyc;
		if (monitorsEn && tMon == 0) tMon = cyc;
		if (alarmsEn && tAlm == 0) tAlm = cyc;
		if (done && tDone == 0) tDone = cyc;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	// Straps move away right after the latch, so only latched values may steer
	task automatic kick(input logic ee, input logic spi);
		gpioCfgSel <= selQ;
		gpioSpiSel <= spi;
		gpioEeEn <= ee;
		master_reset_n <= 1'b0;
		@(posedge core_clk);
		master_reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		gpioCfgSel <= ~selQ;
		gpioSpiSel <= ~spi;
		gpioEeEn <= ~ee;
	endtask

	task automatic runSeq(input logic [21:0] k, input logic ee, input logic spi, input logic hot);
		logic ok;
		logic hit;
		logic ld;
		int idle;
		knobs <= k;
		otpHotfix <= hot;
		selQ = 4'($random(seed));
		master_reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		cmpVal({outputsEn, slavePortEn, alarmsEn, done}, 0);
		{probeIdx, updSeen, pllSeen, hotSeen, tPort, tOut, tMon, tAlm, tDone} = '0;
		kick(ee, spi);
		idle = 0;
		// A sequence parked after an update restart is started again
		while (done !== 1'b1) begin
			@(posedge core_clk);
			idle = ({updReq, otpReq, eeProbeReq, eeBlockReq, hotfixReq} == 0) ? idle + 1 : 0;
			if (idle == 60) kick(ee, spi);
		end
		@(posedge core_clk);
		ok = k[1] & k[2];
		hit = ee & (k[9:3] >= EE_ADDR_FIRST) & (k[9:3] <= EE_ADDR_LAST);
		ld = ok | (hit & (k[11:10] != 2'd3));
		cmpVal(resetStatus, {!ld, hit & (k[11:10] != 0), ee & !hit, k[1] & !k[2], !k[1]});
		cmpVal({loadedCfgValid, ok ? loadedCfgNum : 4'h0}, {ok, ok ? selQ : 4'h0});
		cmpVal(slavePortMode, ld ? k[13:12] : (spi ? PORT_SPI4 : PORT_I2C));
		cmpVal(powerOn, ld ? k[17:14] : 4'h0);
		cmpVal(pllSeen != 0, ld);
		cmpVal(hotSeen, hot);
		cmpVal(updSeen, ee ? 1 + k[0] : 0);
		cmpVal(probeIdx, ee ? (hit ? k[9:3] - EE_ADDR_FIRST + 1 : 24) : 0);
		cmpVal({8'(tOut - tPort), 8'(tMon - tOut), 8'(tAlm - tMon), 8'(tDone - tAlm)},
			32'h01010100);
	endtask

	function automatic logic [21:0] mk(input logic u, input logic h, input logic g,
		input logic [6:0] a, input logic [1:0] b);
		mk = {8'($random(seed)), 2'($unsigned($random(seed)) % 3), b, a, g, h, u};
	endfunction

	initial begin
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
		cmpVal({done, slavePortEn, outputsEn, resetStatus}, 0);
		runSeq(mk(0, 1, 1, 7'h00, 2'd0), 0, 1, 0);
		runSeq(mk(0, 0, 0, 7'h00, 2'd0), 0, 1, 1);
		runSeq(mk(0, 1, 0, 7'h00, 2'd0), 1, 0, 1);
		runSeq(mk(1, 0, 0, 7'h53, 2'd2), 1, 1, 1);
		runSeq(mk(0, 1, 1, 7'h57, 2'd3), 1, 0, 1);
		repeat (4) begin
			runSeq(mk(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
				7'h50 + 7'($unsigned($random(seed)) % 9), 2'($random(seed))),
				1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
		end
		final_report();
	end
endmodule // tb
